// ===== design/asr_receiver.sv
// Asynchronous serial receiver with APB registers and sleep/wakeup logic.
// Function
// - Optionally invert receive input before sampling.
// - Receive only while rx_on is set.
// - Frame: start 0, 8/9 data LSB first, stop 1.
// - Completed character fills empty buffer, sets full.
// - Full buffer: set overrun, drop new character.
// - Full flag clears by two-step read sequence.
// - Sample at sixteen times the baud rate.
// - Edge is low after three high samples.
// - Start valid if two of slots 3,5,7 low.
// - Majority of slots 8,9,10 decides each bit.
// - Disagreeing sample sets noise flag on transfer.
// - Resynchronize slot counter on falling edges during data and stop bits.
// - Non-break framing error preloads three high samples.
// - Framing flag set blocks buffer transfers.
// - Sleep suppresses flags except optional idle flag.
// - Idle-line mode wakes after 10/11 idle bits.
// - Waking idle without option leaves idle flag clear.
// - With option an armed idle sets idle flag in sleep too.
// - Idle count starts after start or stop bit.
// - Address-mark mode wakes on character MSB one.
// - Waking address character is received normally.
// - Status read then data read clears full flag.
// - Error flags set with full flag, never on overrun.
// - Idle flag rearms only after a received character.
//
// Chosen here: the register addresses and the APB slave port.
module asr_receiver #(
	parameter logic [15:0] BAUD_DIV_RST = asr_pkg::BAUD_RST
)
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line.
	input wire logic rxd
);
	import asr_pkg::*;

	if (BAUD_DIV_RST == 16'h0000)
	begin : g_check
		$error("Baud divisor reset value must be nonzero.");
	end

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	asr_ctrl_s ctrl_q, ctrl_d;
	asr_stat_s stat_q, stat_d, snap_q, snap_d;
	asr_state_e state_q, state_d;
	logic [15:0] baud_q, div_cnt_q, div_cnt_d;
	logic [31:0] prdata_q, rd_mux;
	logic [4:0] slot_q, slot_d, cur_w;
	logic [3:0] bit_q, bit_d, nbits_w;
	logic [2:0] hist_q, hist_d, vote_q, vote_d, v3_w;
	logic [8:0] shift_q, shift_d, data_q, data_d;
	logic [7:0] idle_cnt_q, idle_cnt_d, idle_tgt_w;
	logic rx_meta_q, rx_sync_q, noise_q, noise_d;
	logic idle_armed_q, idle_armed_d, clr_arm_q, clr_arm_d;
	logic line_w, tick_w, run_w, edge_w, maj_w, mixed_w, done_w;
	logic load_w, ovr_w, idle_ev_w, idle_set_w, sleep_clr_w, clr_w;
	logic sel_ctrl, sel_stat, sel_data, sel_baud, hit_w;
	logic setup_w, wr_en, rd_en, idle_run_w, addr_wake_w;

	// APB decode. The slave never waits, so every access takes two cycles.
	assign sel_ctrl = paddr == ADDR_CTRL;
	assign sel_stat = paddr == ADDR_STAT;
	assign sel_data = paddr == ADDR_DATA;
	assign sel_baud = paddr == ADDR_BAUD;
	assign hit_w = sel_ctrl | sel_stat | sel_data | sel_baud;
	assign setup_w = psel & ~penable;
	assign wr_en = psel & penable & pwrite & hit_w;
	assign rd_en = psel & penable & ~pwrite & hit_w;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_w;
	assign prdata = prdata_q;
	assign rd_mux = sel_ctrl ? {25'h0, ctrl_q} :
		sel_stat ? {26'h0, state_q != ST_HUNT, stat_q} :
		sel_data ? {23'h0, data_q} :
		sel_baud ? {16'h0, baud_q} : 32'h0;

	// Read data is captured in the setup cycle so that it comes from a flop.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0;
		else if (setup_w)
			prdata_q <= rd_mux;
	end

	// Two-step clear: the status read snapshots what software saw, the
	// following data read clears exactly those flags.
	assign clr_w = rd_en & sel_data & clr_arm_q;
	assign clr_arm_d = (rd_en & sel_stat) ? 1'b1 :
		(rd_en & sel_data) ? 1'b0 : clr_arm_q;
	assign snap_d = (rd_en & sel_stat) ? prdata_q[STAT_W-1:0] : snap_q;

	// Sample tick at sixteen times the baud rate.
	assign tick_w = ctrl_q.rx_on & (baud_q != 16'h0)
		& (div_cnt_q == baud_q - 16'h1);
	assign div_cnt_d = (tick_w | ~ctrl_q.rx_on) ? 16'h0
		: div_cnt_q + 16'h1;

	// The polarity is applied behind the synchroniser, ahead of all sampling.
	assign line_w = rx_sync_q ^ ctrl_q.rx_polarity_invert;
	assign run_w = tick_w & ctrl_q.rx_on;
	assign edge_w = ~line_w & (hist_q == HIST_HIGH);
	assign cur_w = (slot_q == SLOT_LAST) ? SLOT_FIRST : slot_q + 5'h1;
	assign v3_w = {vote_q[1:0], line_w};
	assign maj_w = maj3(v3_w);
	assign mixed_w = (v3_w != 3'h0) & (v3_w != 3'h7);
	assign nbits_w = ctrl_q.nine_bit ? BITS_9 : BITS_8;
	assign done_w = run_w & (state_q == ST_FRAME) & (cur_w == SLOT_M10)
		& (bit_q == nbits_w + 4'h1);
	assign addr_wake_w = run_w & (state_q == ST_FRAME)
		& (cur_w == SLOT_M10) & (bit_q == nbits_w) & maj_w
		& ctrl_q.wake_sel & ctrl_q.rx_sleep;

	// Transfer gating: sleep suppresses, a standing framing error blocks.
	assign load_w = done_w & ~ctrl_q.rx_sleep
		& ~stat_q.framing_error_flag
		& ~stat_q.rx_buffer_full_flag;
	assign ovr_w = done_w & ~ctrl_q.rx_sleep
		& ~stat_q.framing_error_flag
		& stat_q.rx_buffer_full_flag;

	// Idle detection counts high samples of one whole character.
	assign idle_tgt_w = ctrl_q.nine_bit ? IDLE_TICKS_9 : IDLE_TICKS_8;
	assign idle_run_w = ctrl_q.idle_count_start_select ?
		(state_q == ST_HUNT) : (state_q != ST_START);
	assign idle_ev_w = run_w & idle_run_w & line_w
		& (idle_cnt_q == idle_tgt_w - 8'h1);
	assign sleep_clr_w = addr_wake_w | (idle_ev_w & ctrl_q.rx_sleep
		& ~ctrl_q.wake_sel);
	assign idle_set_w = idle_ev_w & idle_armed_q & (~ctrl_q.rx_sleep
		| ctrl_q.idle_during_sleep_option);
	assign idle_cnt_d = (~run_w) ? idle_cnt_q :
		(~line_w | ~idle_run_w) ? 8'h0 :
		(idle_cnt_q == idle_tgt_w) ? idle_cnt_q : idle_cnt_q + 8'h1;
	assign idle_armed_d = load_w ? 1'b1 :
		idle_set_w ? 1'b0 : idle_armed_q;

	// Receive sequencer, stepped once per sample tick.
	always_comb
	begin
		state_d = state_q;
		slot_d = slot_q;
		bit_d = bit_q;
		hist_d = hist_q;
		vote_d = vote_q;
		shift_d = shift_q;
		noise_d = noise_q;
		if (!ctrl_q.rx_on)
		begin
			state_d = ST_HUNT;
		end
		else if (run_w)
		begin
			hist_d = {hist_q[1:0], line_w};
			case (state_q)
				ST_HUNT:
				begin
					if (edge_w)
					begin
						state_d = ST_START;
						slot_d = SLOT_FIRST;
						shift_d = 9'h0;
						noise_d = 1'b0;
					end
				end
				ST_START:
				begin
					slot_d = cur_w;
					if (cur_w == SLOT_S3 || cur_w == SLOT_S5 || cur_w == SLOT_S7)
						vote_d = v3_w;
					if (cur_w == SLOT_S7 && maj_w)
						state_d = ST_HUNT;
					if (cur_w >= SLOT_M8 && cur_w <= SLOT_M10 && line_w)
						noise_d = 1'b1;
					if (cur_w == SLOT_LAST)
					begin
						state_d = ST_FRAME;
						bit_d = 4'h1;
					end
				end
				ST_FRAME:
				begin
					slot_d = edge_w ? SLOT_FIRST : cur_w;
					if (cur_w >= SLOT_M8 && cur_w <= SLOT_M10)
						vote_d = v3_w;
					if (cur_w == SLOT_M10)
					begin
						noise_d = noise_q | mixed_w;
						if (bit_q <= nbits_w)
							shift_d[bit_q - 4'h1] = maj_w;
					end
					if (cur_w == SLOT_LAST || (edge_w && cur_w > SLOT_M10))
						bit_d = bit_q + 4'h1;
					if (done_w)
					begin
						state_d = ST_HUNT;
						if (!maj_w && shift_q != 9'h0)
							hist_d = HIST_HIGH;
					end
				end
				default:
				begin
					state_d = ST_HUNT;
				end
			endcase
		end
	end

	// Status flags. Hardware sets win over the software clear sequence.
	always_comb
	begin
		stat_d = stat_q;
		data_d = data_q;
		if (clr_w)
			stat_d = stat_q & ~snap_q;
		if (load_w)
		begin
			data_d = ctrl_q.nine_bit ? shift_q : {1'b0, shift_q[7:0]};
			stat_d.rx_buffer_full_flag = 1'b1;
			stat_d.noise_flag = stat_d.noise_flag | noise_d;
			stat_d.framing_error_flag = stat_d.framing_error_flag
				| ~maj_w;
		end
		if (ovr_w)
			stat_d.overrun_flag = 1'b1;
		if (idle_set_w)
			stat_d.idle_flag = 1'b1;
	end

	// Control register; a software write wins over the automatic wakeup.
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (sleep_clr_w)
			ctrl_d.rx_sleep = 1'b0;
		if (wr_en && sel_ctrl)
			ctrl_d = pwdata[CTRL_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end
		else
		begin
			rx_meta_q <= rxd;
			rx_sync_q <= rx_meta_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= CTRL_RST;
			baud_q <= BAUD_DIV_RST;
			stat_q <= STAT_RST;
			snap_q <= STAT_RST;
			clr_arm_q <= 1'b0;
			data_q <= 9'h0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			if (wr_en && sel_baud)
				baud_q <= pwdata[15:0];
			stat_q <= stat_d;
			snap_q <= snap_d;
			clr_arm_q <= clr_arm_d;
			data_q <= data_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_HUNT;
			slot_q <= SLOT_FIRST;
			bit_q <= 4'h0;
			hist_q <= 3'h0;
			vote_q <= 3'h0;
			shift_q <= 9'h0;
			noise_q <= 1'b0;
			div_cnt_q <= 16'h0;
			idle_cnt_q <= 8'h0;
			idle_armed_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			slot_q <= slot_d;
			bit_q <= bit_d;
			hist_q <= hist_d;
			vote_q <= vote_d;
			shift_q <= shift_d;
			noise_q <= noise_d;
			div_cnt_q <= div_cnt_d;
			idle_cnt_q <= idle_cnt_d;
			idle_armed_q <= idle_armed_d;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_off_hunt;
		!ctrl_q.rx_on |=> state_q == ST_HUNT;
	endproperty
	a_off_hunt: assert property (p_off_hunt) else $error("Receiver ran while off.");

	property p_edge_start;
		run_w && state_q == ST_HUNT && !line_w && hist_q == 3'h7
			|=> state_q == ST_START && slot_q == 5'h01;
	endproperty
	a_edge_start: assert property (p_edge_start) else $error("Edge missed.");

	property p_load;
		load_w |=> stat_q.rx_buffer_full_flag && data_q[7:0] == $past(shift_q[7:0]);
	endproperty
	a_load: assert property (p_load) else $error("Character not loaded.");

	property p_overrun;
		done_w && stat_q.rx_buffer_full_flag && !ctrl_q.rx_sleep
			&& !stat_q.framing_error_flag
			|=> stat_q.overrun_flag && $stable(data_q);
	endproperty
	a_overrun: assert property (p_overrun) else $error("Overrun mishandled.");

	property p_fe_block;
		stat_q.framing_error_flag && done_w |=> $stable(data_q);
	endproperty
	a_fe_block: assert property (p_fe_block) else $error("Transfer with framing error.");

	property p_sleep_quiet;
		ctrl_q.rx_sleep |=> !$rose(stat_q.rx_buffer_full_flag)
			&& !$rose(stat_q.overrun_flag);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("Flag set while asleep.");

	property p_idle_wake;
		idle_ev_w && ctrl_q.rx_sleep && !ctrl_q.wake_sel
			&& !(wr_en && sel_ctrl) |=> !ctrl_q.rx_sleep;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("Idle did not wake.");

	property p_idle_silent;
		idle_ev_w && ctrl_q.rx_sleep && !ctrl_q.idle_during_sleep_option
			|=> !$rose(stat_q.idle_flag);
	endproperty
	a_idle_silent: assert property (p_idle_silent) else $error("Idle flag set in sleep.");

	property p_clear;
		clr_w && snap_q.rx_buffer_full_flag && !load_w
			|=> !stat_q.rx_buffer_full_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("Full flag not cleared.");

	property p_fe_preload;
		done_w && !maj_w && shift_q != 9'h0 |=> hist_q == 3'h7;
	endproperty
	a_fe_preload: assert property (p_fe_preload) else $error("No preload.");
endmodule

// ===== design/asr_pkg.sv
// Register map, field layouts, state types and timing constants of the receiver.
package asr_pkg;
	// Register byte addresses on the APB bus.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_BAUD = 8'h0c;

	// Control register, rx_on is bit 0 and the last field is bit 6.
	typedef struct packed {
		logic idle_count_start_select;
		logic idle_during_sleep_option;
		logic rx_polarity_invert;
		logic nine_bit;
		logic wake_sel;
		logic rx_sleep;
		logic rx_on;
	} asr_ctrl_s;

	// Status flags, rx_buffer_full_flag is bit 0.
	typedef struct packed {
		logic framing_error_flag;
		logic noise_flag;
		logic overrun_flag;
		logic idle_flag;
		logic rx_buffer_full_flag;
	} asr_stat_s;

	typedef enum logic [1:0] {ST_HUNT, ST_START, ST_FRAME} asr_state_e;

	localparam int CTRL_W = 7;
	localparam int STAT_W = 5;
	localparam int DATA_W = 9;
	localparam asr_ctrl_s CTRL_RST = 7'h00;
	localparam asr_stat_s STAT_RST = 5'h00;
	localparam logic [15:0] BAUD_RST = 16'h0005;
	localparam int STAT_ACTIVE_POS = 5;

	// Sample slots of one bit time.
	localparam logic [4:0] SLOT_FIRST = 5'h01;
	localparam logic [4:0] SLOT_LAST = 5'h10;
	localparam logic [4:0] SLOT_S3 = 5'h03;
	localparam logic [4:0] SLOT_S5 = 5'h05;
	localparam logic [4:0] SLOT_S7 = 5'h07;
	localparam logic [4:0] SLOT_M8 = 5'h08;
	localparam logic [4:0] SLOT_M10 = 5'h0a;

	// Data bits per character and idle character length in sample ticks.
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	localparam logic [7:0] IDLE_TICKS_8 = 8'ha0;
	localparam logic [7:0] IDLE_TICKS_9 = 8'hb0;
	localparam logic [2:0] HIST_HIGH = 3'h7;
endpackage

// ===== test/asr_tx_model.sv
// Remote serial sender that drives the receive line one frame at a time.
module asr_tx_model
(
	// Clock and line polarity.
	input wire logic pclk,
	input wire logic inv,
	// Serial line.
	output logic txd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic line = 1'b1;

	// The wire itself may be inverted, so the receiver has to undo it.
	assign txd = line ^ inv;

	// One frame at sixteen clocks a bit; bit gb gets a one-clock glitch.
	task automatic send(input logic [8:0] d, input int nb, input logic stop,
		input int gb);
		logic bv;
		for (int i = 0; i < nb + 2; i++)
		begin
			bv = (i == 0) ? 1'b0 : (i > nb) ? stop : d[i - 1];
			for (int s = 0; s < 16; s++)
			begin
				@(posedge pclk);
				line <= bv ^ (i == gb && s == 8);
			end
		end
		@(posedge pclk);
		line <= 1'b1;
	endtask
endmodule

// ===== test/asr_receiver_tb.sv
// Self-checking bench for the serial receiver fed by a remote sender.
module asr_receiver_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import asr_pkg::*;

	localparam logic [31:0] FM = 32'h0000001d;
	localparam logic [31:0] AM = 32'hffffffff;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxd;
	logic inv = 1'b0;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int total_checks = 0;

	asr_receiver #(.BAUD_DIV_RST(16'h0001)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd));
	asr_tx_model tx (.pclk(pclk), .inv(inv), .txd(rxd));

	initial forever #50 pclk = ~pclk;

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input logic [31:0] m);
		total_checks++;
		if ((g & m) !== e)
		begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	// Holds the request until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			conclude();
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(1'b0, a, 32'h00000000);
		chk(rd, e, m);
	endtask

	task automatic bits(input int n);
		repeat (n * 16) @(posedge pclk);
	endtask

	task automatic t_reset();
		rdc(ADDR_CTRL, 32'h0, AM);
		rdc(ADDR_BAUD, 32'h1, AM);
		rdc(ADDR_STAT, 32'h0, AM);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1, AM);
		chk(rd, 32'h0, AM);
		apb(1'b1, ADDR_STAT, 32'h1f);
		tx.send(9'h0a5, 8, 1'b1, 99);
		rdc(ADDR_STAT, 32'h0, FM);
		$display("test reset done");
	endtask

	task automatic t_basic();
		apb(1'b1, ADDR_CTRL, 32'h1);
		tx.send(9'h0a5, 8, 1'b1, 99);
		rdc(ADDR_DATA, 32'h0a5, AM);
		rdc(ADDR_STAT, 32'h1, FM);
		rdc(ADDR_DATA, 32'h0a5, AM);
		rdc(ADDR_STAT, 32'h0, FM);
		tx.send(9'h03c, 8, 1'b1, 99);
		tx.send(9'h0c3, 8, 1'b1, 99);
		rdc(ADDR_STAT, 32'h5, FM);
		rdc(ADDR_DATA, 32'h03c, AM);
		rdc(ADDR_STAT, 32'h0, FM);
		$display("test basic done");
	endtask

	// A framing error must lock out later characters until cleared.
	task automatic t_frame();
		tx.send(9'h055, 8, 1'b0, 99);
		// The preloaded history finds a start in the low stop bit, so let
		// that phantom frame run out before the next real character.
		bits(12);
		rdc(ADDR_STAT, 32'h11, FM);
		tx.send(9'h03c, 8, 1'b1, 99);
		rdc(ADDR_STAT, 32'h11, FM);
		rdc(ADDR_DATA, 32'h055, AM);
		rdc(ADDR_STAT, 32'h0, FM);
		tx.send(9'h00f, 8, 1'b1, 6);
		rdc(ADDR_STAT, 32'h9, FM);
		rdc(ADDR_DATA, 32'h00f, AM);
		$display("test frame done");
	endtask

	task automatic t_nine();
		apb(1'b1, ADDR_CTRL, 32'h19);
		inv <= 1'b1;
		bits(1);
		tx.send(9'h1a5, 9, 1'b1, 99);
		rdc(ADDR_STAT, 32'h1, FM);
		rdc(ADDR_DATA, 32'h1a5, AM);
		apb(1'b1, ADDR_CTRL, 32'h1);
		inv <= 1'b0;
		bits(1);
		$display("test nine done");
	endtask

	task automatic t_mark();
		apb(1'b1, ADDR_CTRL, 32'h7);
		tx.send(9'h012, 8, 1'b1, 99);
		rdc(ADDR_STAT, 32'h0, FM);
		rdc(ADDR_CTRL, 32'h7, AM);
		tx.send(9'h092, 8, 1'b1, 99);
		rdc(ADDR_CTRL, 32'h5, AM);
		rdc(ADDR_STAT, 32'h1, FM);
		rdc(ADDR_DATA, 32'h092, AM);
		$display("test mark done");
	endtask

	// The wake must not come before a whole idle character has passed.
	task automatic t_idle();
		apb(1'b1, ADDR_CTRL, 32'h3);
		tx.send(9'h000, 8, 1'b1, 99);
		bits(8);
		rdc(ADDR_CTRL, 32'h3, AM);
		bits(3);
		rdc(ADDR_CTRL, 32'h1, AM);
		rdc(ADDR_STAT, 32'h0, 32'h2);
		// Trailing ones must not count when idle starts after the stop bit.
		apb(1'b1, ADDR_CTRL, 32'h43);
		tx.send(9'h0f0, 8, 1'b1, 99);
		bits(8);
		rdc(ADDR_CTRL, 32'h43, AM);
		bits(2);
		rdc(ADDR_CTRL, 32'h41, AM);
		apb(1'b1, ADDR_CTRL, 32'h23);
		tx.send(9'h000, 8, 1'b1, 99);
		bits(12);
		rdc(ADDR_CTRL, 32'h21, AM);
		rdc(ADDR_STAT, 32'h2, 32'h3);
		$display("test idle done");
	endtask

	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_basic();
		t_frame();
		t_nine();
		t_mark();
		t_idle();
		conclude();
	end
endmodule
